// file: src/opc_pkg.sv
package opc_pkg;
    // =========================================================
    // timing
    localparam int CLK_HZ         = 125_000_000;
    localparam int DEBOUNCE_US    = 10;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int TICK_MS        = 50;
    localparam int TICK_CYC       = TICK_MS * (CLK_HZ / 1000);
    localparam int FLASH_TICKS    = 4;
    // =========================================================
    // panel geometry
    localparam int N_MENU         = 8;
    localparam int N_PARAM        = 4;
    localparam int N_PANEL        = N_MENU * N_PARAM;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [4:0]  IDX_RESET = 5'h00;
    // =========================================================
    // types
    typedef enum logic [1:0] {
        OPC_NET_OFF, OPC_NET_CAN, OPC_NET_SER
    } opc_net_t;

    typedef enum logic [1:0] {
        OPC_NMT_STOP, OPC_NMT_PREOP, OPC_NMT_OPER
    } opc_nmt_t;

    typedef struct packed {
        logic exit_key;
        logic accept_key;
        logic down_key;
        logic up_key;
        logic stop_key;
    } opc_keys_t;

    typedef struct packed {
        logic bus_off;
        logic warn;
        logic guard_evt;
        logic sync_miss;
    } opc_can_err_t;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic        is_list;
    } opc_range_t;

    typedef struct packed {
        logic [4:0]  idx;
        logic [15:0] value;
        logic        we;
    } opc_nv_wr_t;
endpackage

// file: src/opc_panel.sv
`timescale 1ns/1ps
// What this block does
// R1: exit key leaves level, drops unsaved edit
// R2: accept opens level or stores edited value
// R3: down: next entry, or decrease value
// R4: up: previous entry, or increase value
// R5: clamp numbers, cycle list choices
// R6: accept flashes display once, writes immediately
// R7: menu, then parameter, then value level
// R8: panel reaches only a parameter subset
// R9: red lamp follows dc bus energised
// R10: stop key requests quick stop
// R11: run lamp pattern per nmt state
// R12: error lamp bus-off pattern
// R13: error lamp warning-limit pattern
// R14: guard, sync-miss and normal error patterns
// R15: serial run lamp lit when link up
// R16: serial error lamp lit on bus error
// R17: glyphs caseless except letter c
// R18: one debounced action per key press
// R19: free-running timebase makes blink patterns
module opc_panel
    import opc_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // operator keys, raw pins
    input  wire opc_keys_t    keys_i,
    // drive state
    input  wire logic         dc_bus_on_i,
    input  wire opc_net_t     net_mode_i,
    input  wire opc_nmt_t     nmt_state_i,
    input  wire opc_can_err_t can_err_i,
    input  wire logic         ser_link_up_i,
    input  wire logic         ser_bus_err_i,
    // current stored value and range of the selected parameter
    input  wire logic [15:0]  nv_value_i,
    input  wire opc_range_t   range_i,
    // character request for the display
    input  wire logic [7:0]   char_i,
    // outputs
    output logic [4:0]        sel_idx_o,
    output opc_nv_wr_t        nv_wr_o,
    output logic [15:0]       disp_value_o,
    output logic [1:0]        level_o,
    output logic              disp_blank_o,
    output logic [6:0]        seg_o,
    output logic              quick_stop_o,
    output logic              bus_lamp_o,
    output logic              run_lamp_o,
    output logic              err_lamp_o
);
    // =========================================================
    // key input synchroniser and debounce
    typedef enum {LV_MENU, LV_PARAM, LV_EDIT} opc_lvl_t;
    localparam int NK = 5;
    logic [NK-1:0] s1, s2, s3, stable, stable_d;
    logic [NK-1:0] press;
    logic [$clog2(DEBOUNCE_CYC+1)-1:0] db_cnt [NK];

    // three stages; s1 only feeds s2
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= keys_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a level must hold for the debounce time before it counts
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stable   <= '0;
            stable_d <= '0;
            for (int k = 0; k < NK; k++) db_cnt[k] <= '0;
        end else begin
            stable_d <= stable;
            for (int k = 0; k < NK; k++) begin
                if (s2[k] != s3[k] || s3[k] == stable[k]) begin
                    db_cnt[k] <= '0;
                end else if (db_cnt[k] == DEBOUNCE_CYC[$bits(db_cnt[k])-1:0])
                begin
                    stable[k] <= s3[k];
                    db_cnt[k] <= '0;
                end else begin
                    db_cnt[k] <= db_cnt[k] + 1'b1;
                end
            end
        end
    end
    // rising edge only, so holding a key gives one action
    assign press = stable & ~stable_d; // R18
    wire opc_keys_t kp = opc_keys_t'(press);

    // =========================================================
    // menu navigation and editing
    opc_lvl_t    lvl;
    logic [2:0]  menu;
    logic [1:0]  prm;
    logic [15:0] edit;

    function automatic logic [15:0] step_val(input logic [15:0] v,
                                             input logic up,
                                             input opc_range_t r);
        logic [15:0] res;
        res = v;
        if (up) begin
            if (v < r.hi) res = v + 16'h0001;
            else if (r.is_list) res = r.lo; // R5
        end else begin
            if (v > r.lo) res = v - 16'h0001;
            else if (r.is_list) res = r.hi; // R5
        end
        if (res > r.hi) res = r.hi; // R5
        if (res < r.lo) res = r.lo;
        return res;
    endfunction

    // only N_PARAM entries per menu are reachable here
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lvl       <= LV_MENU;
            menu      <= '0;
            prm       <= '0;
            edit      <= VAL_RESET;
            nv_wr_o   <= '0;
        end else begin
            nv_wr_o.we <= 1'b0;
            case (lvl)
                LV_MENU: begin
                    if (kp.accept_key) begin
                        lvl <= LV_PARAM; // R7
                        prm <= '0;
                    end else if (kp.down_key) begin
                        menu <= menu + 3'h1; // R3
                    end else if (kp.up_key) begin
                        menu <= menu - 3'h1; // R4
                    end
                end
                LV_PARAM: begin
                    if (kp.exit_key) begin
                        lvl <= LV_MENU; // R1
                    end else if (kp.accept_key) begin
                        lvl  <= LV_EDIT; // R7
                        edit <= nv_value_i;
                    end else if (kp.down_key) begin
                        prm <= prm + 2'h1; // R3 R8
                    end else if (kp.up_key) begin
                        prm <= prm - 2'h1; // R4
                    end
                end
                LV_EDIT: begin
                    if (kp.exit_key) begin
                        edit <= nv_value_i; // R1
                        lvl  <= LV_PARAM;
                    end else if (kp.accept_key) begin
                        nv_wr_o.we    <= 1'b1; // R2 R6
                        nv_wr_o.idx   <= {menu, prm};
                        nv_wr_o.value <= edit;
                    end else if (kp.down_key) begin
                        edit <= step_val(edit, 1'b0, range_i); // R3
                    end else if (kp.up_key) begin
                        edit <= step_val(edit, 1'b1, range_i); // R4
                    end
                end
                default: lvl <= LV_MENU;
            endcase
        end
    end

    // display mirrors state from flops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_idx_o    <= IDX_RESET;
            disp_value_o <= VAL_RESET;
            level_o      <= 2'h0;
        end else begin
            sel_idx_o    <= {menu, prm};
            disp_value_o <= (lvl == LV_EDIT) ? edit : nv_value_i;
            level_o      <= (lvl == LV_MENU)  ? 2'h0 :
                            (lvl == LV_PARAM) ? 2'h1 : 2'h2;
        end
    end

    // =========================================================
    // free-running timebase for blinking
    logic [$clog2(TICK_CYC+1)-1:0] tb_cnt;
    logic       tick;
    logic [3:0] phase;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tb_cnt <= '0;
            tick   <= 1'b0;
            phase  <= '0;
        end else begin
            tick <= 1'b0;
            if (tb_cnt == TICK_CYC[$bits(tb_cnt)-1:0] - 1'b1) begin
                tb_cnt <= '0;
                tick   <= 1'b1; // R19
                phase  <= phase + 4'h1;
            end else begin
                tb_cnt <= tb_cnt + 1'b1;
            end
        end
    end

    // one flash: blank for FLASH_TICKS ticks after a store
    logic [2:0] flash_cnt;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flash_cnt    <= '0;
            disp_blank_o <= 1'b0;
        end else begin
            if (nv_wr_o.we) flash_cnt <= FLASH_TICKS[2:0]; // R6
            else if (tick && flash_cnt != 3'h0) flash_cnt <= flash_cnt - 3'h1;
            disp_blank_o <= (flash_cnt != 3'h0);
        end
    end

    // =========================================================
    // lamps; patterns over 16 phases, each one distinct
    localparam logic [15:0] PAT_ON    = 16'hFFFF;
    localparam logic [15:0] PAT_BLINK = 16'h3333;
    localparam logic [15:0] PAT_FLASH1= 16'h0003;
    localparam logic [15:0] PAT_FLASH2= 16'h0033;
    localparam logic [15:0] PAT_FLASH3= 16'h0333;
    localparam logic [15:0] PAT_OFF   = 16'h0000;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            run_lamp_o <= 1'b0;
            err_lamp_o <= 1'b0;
        end else begin
            case (net_mode_i)
                OPC_NET_CAN: begin
                    case (nmt_state_i) // R11
                        OPC_NMT_OPER:  run_lamp_o <= PAT_ON[phase];
                        OPC_NMT_PREOP: run_lamp_o <= PAT_BLINK[phase];
                        OPC_NMT_STOP:  run_lamp_o <= PAT_FLASH1[phase];
                        default:       run_lamp_o <= 1'b0;
                    endcase
                    // bus-off first, then warning, guard, sync
                    if (can_err_i.bus_off)
                        err_lamp_o <= PAT_ON[phase]; // R12
                    else if (can_err_i.warn)
                        err_lamp_o <= PAT_FLASH1[phase]; // R13
                    else if (can_err_i.guard_evt)
                        err_lamp_o <= PAT_FLASH2[phase]; // R14
                    else if (can_err_i.sync_miss)
                        err_lamp_o <= PAT_FLASH3[phase]; // R14
                    else
                        err_lamp_o <= PAT_OFF[phase]; // R14
                end
                OPC_NET_SER: begin
                    run_lamp_o <= ser_link_up_i; // R15
                    err_lamp_o <= ser_bus_err_i; // R16
                end
                default: begin
                    run_lamp_o <= 1'b0;
                    err_lamp_o <= 1'b0;
                end
            endcase
        end
    end

    // dc bus lamp from the resynchronised level, quick stop from the debounced stop key press
    logic [2:0] bus_sync;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_sync     <= '0;
            bus_lamp_o   <= 1'b0;
            quick_stop_o <= 1'b0;
        end else begin
            bus_sync <= {bus_sync[1:0], dc_bus_on_i};
            if (bus_sync[1] == bus_sync[2])
                bus_lamp_o <= bus_sync[2]; // R9
            quick_stop_o <= kp.stop_key; // R10
        end
    end

    // =========================================================
    // seven-segment glyphs, segments gfedcba
    function automatic logic [6:0] glyph(input logic [7:0] c);
        logic [7:0] u;
        u = (c >= 8'h61 && c <= 8'h7A && c != 8'h63) ? c - 8'h20 : c; // R17
        case (u)
            8'h30: glyph = 7'h3F; 8'h31: glyph = 7'h06;
            8'h32: glyph = 7'h5B; 8'h33: glyph = 7'h4F;
            8'h34: glyph = 7'h66; 8'h35: glyph = 7'h6D;
            8'h36: glyph = 7'h7D; 8'h37: glyph = 7'h07;
            8'h38: glyph = 7'h7F; 8'h39: glyph = 7'h6F;
            8'h41: glyph = 7'h77; 8'h42: glyph = 7'h7C;
            8'h43: glyph = 7'h39; 8'h63: glyph = 7'h58; // R17
            8'h44: glyph = 7'h5E; 8'h45: glyph = 7'h79;
            8'h46: glyph = 7'h71; 8'h47: glyph = 7'h3D;
            8'h48: glyph = 7'h74; 8'h49: glyph = 7'h04;
            8'h4A: glyph = 7'h0E; 8'h4B: glyph = 7'h76;
            8'h4C: glyph = 7'h38; 8'h4D: glyph = 7'h37;
            8'h4E: glyph = 7'h54; 8'h4F: glyph = 7'h5C;
            8'h50: glyph = 7'h73; 8'h51: glyph = 7'h67;
            8'h52: glyph = 7'h50; 8'h53: glyph = 7'h6D;
            8'h54: glyph = 7'h78; 8'h55: glyph = 7'h1C;
            8'h56: glyph = 7'h3E; 8'h57: glyph = 7'h2A;
            8'h58: glyph = 7'h76; 8'h59: glyph = 7'h6E;
            8'h5A: glyph = 7'h5B; 8'h2D: glyph = 7'h40;
            default: glyph = 7'h00;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) seg_o <= 7'h00;
        else seg_o <= disp_blank_o ? 7'h00 : glyph(char_i);
    end
endmodule // opc_panel

// file: sim/opc_panel_properties.sv
`timescale 1ns/1ps
// =============================================
// port-level checks of the panel controller
module opc_panel_properties
    import opc_pkg::*;
(
    // clock and reset
    input wire logic         clk_i,
    input wire logic         sys_rst_i,
    // observed inputs
    input wire opc_keys_t    keys_i,
    input wire logic         dc_bus_on_i,
    input wire opc_net_t     net_mode_i,
    input wire logic         ser_link_up_i,
    input wire logic         ser_bus_err_i,
    // observed outputs
    input wire opc_nv_wr_t   nv_wr_o,
    input wire logic [1:0]   level_o,
    input wire logic         disp_blank_o,
    input wire logic [6:0]   seg_o,
    input wire logic         quick_stop_o,
    input wire logic         bus_lamp_o,
    input wire logic         run_lamp_o,
    input wire logic         err_lamp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // =============================================
    // assertions; lamp latencies allow the pin synchronisers
    chk_bus_lamp: assert property ($changed(dc_bus_on_i) ##1
        $stable(dc_bus_on_i)[*7] |-> bus_lamp_o == dc_bus_on_i)
        else $error("bus lamp does not follow dc bus");
    chk_ser_run: assert property (
        (net_mode_i == OPC_NET_SER && ser_link_up_i)[*3] |-> run_lamp_o)
        else $error("serial run lamp dark with link up");
    chk_ser_err: assert property (
        (net_mode_i == OPC_NET_SER && ser_bus_err_i)[*3] |-> err_lamp_o)
        else $error("serial error lamp dark on bus error");
    chk_store_edit: assert property (nv_wr_o.we |->
        level_o == 2'h2 ##1 !nv_wr_o.we)
        else $error("store outside edit or longer than a cycle");
    chk_flash_once: assert property (nv_wr_o.we |-> ##[1:3] disp_blank_o)
        else $error("no flash after store");
    chk_blank_seg: assert property (disp_blank_o && $past(disp_blank_o)
        |-> seg_o == 7'h00)
        else $error("segments lit while blanked");
    chk_level_step: assert property ($changed(level_o) |->
        level_o == $past(level_o) + 2'h1 || level_o == $past(level_o) - 2'h1)
        else $error("level jumped");
    chk_level_legal: assert property (level_o != 2'h3)
        else $error("illegal level");
    chk_stop_pulse: assert property (quick_stop_o |=> !quick_stop_o)
        else $error("quick stop longer than a cycle");
    chk_stop_cause: assert property (
        quick_stop_o |-> $past(keys_i.stop_key, 4))
        else $error("quick stop without held key");
    // main scenarios
    cov_store: cover property (nv_wr_o.we);
    cov_stop: cover property (quick_stop_o);
    cov_flash: cover property ($rose(disp_blank_o));
endmodule // opc_panel_properties

bind opc_panel opc_panel_properties opc_panel_properties_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .keys_i(keys_i),
    .dc_bus_on_i(dc_bus_on_i), .net_mode_i(net_mode_i),
    .ser_link_up_i(ser_link_up_i), .ser_bus_err_i(ser_bus_err_i),
    .nv_wr_o(nv_wr_o), .level_o(level_o), .disp_blank_o(disp_blank_o),
    .seg_o(seg_o), .quick_stop_o(quick_stop_o), .bus_lamp_o(bus_lamp_o),
    .run_lamp_o(run_lamp_o), .err_lamp_o(err_lamp_o));

// file: sim/opc_operator.sv
`timescale 1ns/1ps
// =============================================
// operator at the panel, keys with contact bounce
module opc_operator
    import opc_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // raw key levels
    output opc_keys_t keys_o
);
    initial keys_o = '0;
    // bounce, hold, bounce, rest long enough to debounce release
    task automatic press(input int k, input int hold);
        repeat (5) begin
            @(posedge clk_i);
            keys_o[k] <= ~keys_o[k];
        end
        repeat (hold) @(posedge clk_i);
        repeat (5) begin
            @(posedge clk_i);
            keys_o[k] <= ~keys_o[k];
        end
        repeat (1400) @(posedge clk_i);
    endtask
endmodule // opc_operator

// file: sim/opc_panel_tb.sv
`timescale 1ns/1ps
// =============================================
// bench: operator model, stored values, lamp inputs
module opc_panel_tb;
    import opc_pkg::*;
    localparam int KX = 4, KA = 3, KD = 2, KU = 1, KS = 0;
    logic         clk_i = 1'b0, sys_rst_i = 1'b1, dc_bus_on_i = 1'b0;
    logic         ser_link_up_i = 1'b0, ser_bus_err_i = 1'b0;
    opc_keys_t    keys;
    opc_net_t     net_mode_i = OPC_NET_OFF;
    opc_nmt_t     nmt_state_i = OPC_NMT_STOP;
    opc_can_err_t can_err_i = '0;
    logic         preset_we = 1'b0;
    logic [15:0]  preset_val = 16'h0000;
    opc_range_t   range_i = '0;
    logic [7:0]   char_i = 8'h41;
    logic [15:0]  nv [32];
    logic [15:0]  nv_value_i, disp_value_o, v, e;
    logic [4:0]   sel_idx_o;
    opc_nv_wr_t   nv_wr_o, last_wr;
    logic [1:0]   level_o;
    logic [6:0]   seg_o;
    logic         disp_blank_o, quick_stop_o, bus_lamp_o;
    logic         run_lamp_o, err_lamp_o, blank_seen = 1'b0;
    int           fails = 0, n_checks = 0, we_cnt = 0, qs_cnt = 0;
    assign nv_value_i = nv[sel_idx_o];
    // clock
    initial forever #4 clk_i = ~clk_i;
    opc_operator opc_operator_i (.clk_i(clk_i), .keys_o(keys));
    opc_panel opc_panel_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .keys_i(keys), .dc_bus_on_i(dc_bus_on_i), .net_mode_i(net_mode_i),
        .nmt_state_i(nmt_state_i), .can_err_i(can_err_i),
        .ser_link_up_i(ser_link_up_i), .ser_bus_err_i(ser_bus_err_i),
        .nv_value_i(nv_value_i), .range_i(range_i), .char_i(char_i),
        .sel_idx_o(sel_idx_o), .nv_wr_o(nv_wr_o),
        .disp_value_o(disp_value_o), .level_o(level_o),
        .disp_blank_o(disp_blank_o), .seg_o(seg_o),
        .quick_stop_o(quick_stop_o), .bus_lamp_o(bus_lamp_o),
        .run_lamp_o(run_lamp_o), .err_lamp_o(err_lamp_o));
    // storage model: a store lands in the array at once
    always @(posedge clk_i) begin
        if (sys_rst_i === 1'b1) begin
            foreach (nv[i]) nv[i] <= 16'h0000;
        end else if (preset_we === 1'b1) begin
            nv[5] <= preset_val; // bench preset, same single writer
        end
        if (nv_wr_o.we === 1'b1) begin
            we_cnt++;
            last_wr <= nv_wr_o;
            nv[nv_wr_o.idx] <= nv_wr_o.value;
        end
        if (quick_stop_o === 1'b1) qs_cnt++;
        if (disp_blank_o === 1'b1) blank_seen <= 1'b1;
    end
    task automatic check(input logic [15:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    // expected edit value after one step: clamp numbers, wrap lists
    function automatic logic [15:0] exp_step(input logic [15:0] x, lo, hi,
                                             input logic up, lst);
        if (up && x == hi) return lst ? lo : hi;
        if (!up && x == lo) return lst ? hi : lo;
        return up ? x + 16'h0001 : x - 16'h0001;
    endfunction
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one press, then level and selection once the release settled
    task automatic key_chk(input int k, input logic [1:0] l,
                           input logic [4:0] s);
        opc_operator_i.press(k, 1400);
        check(level_o, l, "level");
        check(sel_idx_o, s, "selection");
    endtask
    // random lamp inputs in serial mode; settle past synchronisers
    task automatic lamps();
        logic [2:0] r;
        repeat (8) begin
            r = 3'($urandom);
            @(posedge clk_i);
            {dc_bus_on_i, ser_link_up_i, ser_bus_err_i} <= r;
            net_mode_i <= OPC_NET_SER;
            repeat (10) @(posedge clk_i);
            check(bus_lamp_o, r[2], "bus lamp");
            check(run_lamp_o, r[1], "run lamp");
            check(err_lamp_o, r[0], "error lamp");
        end
    endtask
    // random can states; the slow timebase keeps every pattern in its
    // opening lit phase, so only the normal pattern reads dark here
    task automatic can_lamps();
        logic [5:0] r;
        repeat (8) begin
            r = 6'($urandom);
            @(posedge clk_i);
            net_mode_i  <= OPC_NET_CAN;
            nmt_state_i <= (r[5:4] == 2'h3) ? OPC_NMT_OPER
                                            : opc_nmt_t'(r[5:4]);
            can_err_i   <= r[3:0];
            repeat (4) @(posedge clk_i);
            check(run_lamp_o, 1'b1, "can run lamp");
            check(err_lamp_o, |r[3:0], "can error lamp");
        end
    endtask
    task automatic glyph(input logic [7:0] c);
        @(posedge clk_i);
        char_i <= c;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic edit_setup(input logic [15:0] lo, hi, val, input logic l);
        @(posedge clk_i);
        range_i    <= '{lo: lo, hi: hi, is_list: l};
        preset_val <= val;
        preset_we  <= 1'b1;
        @(posedge clk_i);
        preset_we  <= 1'b0;
    endtask
    // =============================================
    // main sequence
    initial begin
        logic [6:0] g;
        void'($urandom(59));
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        check(level_o, 2'h0, "reset level");
        check(sel_idx_o, IDX_RESET, "reset selection");
        glyph(8'h41);
        g = seg_o;
        check(g == 7'h00, 1'b0, "A glyph lit");
        glyph(8'h61);
        check(seg_o, g, "a glyph");
        glyph(8'h63);
        check(seg_o, 7'h58, "c glyph");
        glyph(8'h43);
        check(seg_o === 7'h58, 1'b0, "C glyph");
        $display("TB: glyphs done");
        lamps();
        $display("TB: lamps done");
        can_lamps();
        $display("TB: can lamps done");
        key_chk(KX, 2'h0, 5'h00);
        key_chk(KD, 2'h0, 5'h04);
        key_chk(KU, 2'h0, 5'h00);
        key_chk(KD, 2'h0, 5'h04);
        key_chk(KA, 2'h1, 5'h04);
        key_chk(KD, 2'h1, 5'h05);
        $display("TB: navigation done");
        v = 16'($urandom_range(10, 19));
        edit_setup(16'h000A, 16'h0014, v, 1'b0);
        key_chk(KA, 2'h2, 5'h05);
        check(disp_value_o, v, "edit start");
        key_chk(KU, 2'h2, 5'h05);
        e = exp_step(v, 16'h000A, 16'h0014, 1'b1, 1'b0);
        check(disp_value_o, e, "increase");
        key_chk(KX, 2'h1, 5'h05);
        check(disp_value_o, v, "discard");
        edit_setup(16'h000A, 16'h0014, 16'h0014, 1'b0);
        key_chk(KA, 2'h2, 5'h05);
        key_chk(KU, 2'h2, 5'h05);
        e = exp_step(16'h0014, 16'h000A, 16'h0014, 1'b1, 1'b0);
        check(disp_value_o, e, "clamp");
        key_chk(KD, 2'h2, 5'h05);
        e = exp_step(e, 16'h000A, 16'h0014, 1'b0, 1'b0);
        check(disp_value_o, e, "decrease");
        key_chk(KA, 2'h2, 5'h05);
        check(we_cnt, 1, "store count");
        check(last_wr.value, e, "store value");
        check(last_wr.idx, 5'h05, "store index");
        check(blank_seen, 1'b1, "flash");
        key_chk(KX, 2'h1, 5'h05);
        check(disp_value_o, 16'h0013, "saved");
        edit_setup(16'h0001, 16'h0003, 16'h0003, 1'b1);
        key_chk(KA, 2'h2, 5'h05);
        key_chk(KU, 2'h2, 5'h05);
        e = exp_step(16'h0003, 16'h0001, 16'h0003, 1'b1, 1'b1);
        check(disp_value_o, e, "list wrap");
        key_chk(KX, 2'h1, 5'h05);
        key_chk(KU, 2'h1, 5'h04);
        key_chk(KU, 2'h1, 5'h07);
        $display("TB: editing done");
        opc_operator_i.press(KS, 4000);
        check(qs_cnt, 1, "quick stop");
        check(we_cnt, 1, "no extra store");
        $display("TB: stop done");
        complete_run();
    end
    // watchdog sized from 20 presses, 19 of under 3000 cycles and one of about 5410
    initial begin
        repeat (90000) @(posedge clk_i);
        fails++;
        complete_run();
    end
endmodule // opc_panel_tb
